// >>> inc/apd_map.svh
`ifndef APD_MAP_SVH
`define APD_MAP_SVH
// power mode register 0 fields
`define PMR0_APD_EN_BIT 1
`define PMR0_FULL_SPEED_OFF_BIT 3
`define PMR0_CLK_BLOCK_BIT 4
// power mode register 2 fields
`define PMR2_CNTL0_BIT 2
`define PMR2_CNTL1_BIT 3
`define PMR2_CNTL2_BIT 4
`define PMR2_STROBE_BIT 5
`define PMR2_DBE_BIT 6
`define PMR_RESET_VAL 8'h00
// idle counter
`define IDLE_CNT_W 4
`define IDLE_LIMIT 4'hF
`endif

// >>> inc/apd_pkg.sv
package apd_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_COUNT = 2'b01,
    ST_DOWN = 2'b11
  } apd_state_t;
  typedef struct packed {
    logic [7:0] reg0;
    logic [7:0] reg2;
  } power_mode_t;
  typedef struct packed {
    logic cntl0;
    logic cntl1;
    logic cntl2;
    logic strobe;
    logic dbe;
    logic clk_en;
  } logic_inputs_t;
endpackage : apd_pkg

// >>> rtl/auto_power_down_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "apd_map.svh"

// What this block does
// (RL1) Watch the address latch strobe; its idleness is the only cause of power-down.
// (RL2) When enabled and the strobe is idle, a 4-bit counter advances each common clock period; fifteen idle periods assert power-down.
// (RL3) Setting the automatic power-down enable alone arms power-down mode.
// (RL4) In power-down, host address and data are gated from memories and logic arrays and all memories are deselected.
// (RL5) Renewed strobe pulsing leaves power-down at once.
// (RL6) Chip select going low or reset returning high also leaves power-down.
// (RL7) Blocking the common clock from the logic arrays never stops it reaching the idle counter.
// (RL8) Power-down does not change logic or port behaviour; logic speed follows only the full-speed setting.
// (RL9) In power-down, host I/O and logic-output pins hold, address outputs are undefined, data port pins float.
// (RL10) Chip select high disables only the memories, not the logic arrays nor internal signals.
// (RL11) Host-set blocking bits in the power mode registers keep their signals from both logic arrays, updatable at run time.
// (RL12) Full speed is on after power-up; setting the disable bit lets the arrays idle into standby.
// (RL13) Bit 1 of power mode register 0 enables automatic power-down; at 0 the counter does not run.
// (RL14) The counter runs only while the strobe sits steadily at the configured polarity, and asserts power-down after 15 clocks.
// (RL15) Bit 3 of power mode register 0 set to 1 turns full speed off, 0 turns it on.
// (RL16) Both power mode registers clear only at power-up, not on later reset pulses.
// (RL17) Any strobe activity clears the idle counter to zero.
module auto_power_down_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic common_clock_input,
  input wire logic address_latch_strobe,
  input wire logic strobe_pd_polarity,
  input wire logic chip_select_n,
  input wire logic reg_wr0,
  input wire logic reg_wr2,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_data,
  input wire logic cntl0,
  input wire logic cntl1,
  input wire logic cntl2,
  input wire logic dbe,
  input wire logic [7:0] data_port_out,
  output var apd_pkg::power_mode_t power_mode,
  output var apd_pkg::logic_inputs_t logic_in,
  output logic power_down_signal,
  output logic [`IDLE_CNT_W-1:0] idle_count,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_data,
  output logic mem_select,
  output logic full_speed,
  output logic [7:0] data_port_o,
  output logic [7:0] data_port_oe,
  output logic addr_out_valid
);

  // ****************************************
  // power mode registers
  // ****************************************
  // por_n is the power-up reset; rst_n pulses must not touch these
  apd_pkg::power_mode_t pm_q, pm_d;

  always_comb begin
    pm_d = pm_q;
    if (reg_wr0) begin
      pm_d.reg0 = reg_wdata; // [RL11]
    end
    if (reg_wr2) begin
      pm_d.reg2 = reg_wdata; // [RL11]
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      pm_q <= {`PMR_RESET_VAL, `PMR_RESET_VAL}; // [RL16]
    end else begin
      pm_q <= pm_d;
    end
  end

  logic apd_en;
  assign apd_en = pm_q.reg0[`PMR0_APD_EN_BIT]; // [RL13] [RL3]

  // ****************************************
  // strobe and clock edge detection
  // ****************************************
  // a one-cycle sample history is enough: inputs are synchronous
  logic strobe_q, strobe_d, cclk_q, cclk_d, rst_seen_q, rst_seen_d, cs_q, cs_d;
  logic strobe_act, cclk_rise, idle_level;

  always_comb begin
    strobe_d = address_latch_strobe;
    cclk_d = common_clock_input;
    cs_d = chip_select_n;
    rst_seen_d = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
      cclk_q <= 1'b0;
      cs_q <= 1'b1;
      rst_seen_q <= 1'b0;
    end else begin
      strobe_q <= strobe_d;
      cclk_q <= cclk_d;
      cs_q <= cs_d;
      rst_seen_q <= rst_seen_d;
    end
  end

  assign strobe_act = address_latch_strobe != strobe_q; // [RL1]
  // idle counter sees the raw clock pin regardless of the array clock block
  assign cclk_rise = common_clock_input && !cclk_q; // [RL7]
  assign idle_level = address_latch_strobe == strobe_pd_polarity; // [RL14]

  // ****************************************
  // idle counter and power-down state
  // ****************************************
  apd_pkg::apd_state_t st_q, st_d;
  logic [`IDLE_CNT_W-1:0] cnt_q, cnt_d;
  logic wake;

  // chip select falling edge or reset release both wake the device
  assign wake = strobe_act || (cs_q && !chip_select_n) || !rst_seen_q; // [RL5] [RL6]

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      apd_pkg::ST_RUN: begin
        cnt_d = '0;
        if (apd_en && idle_level && !strobe_act) begin
          st_d = apd_pkg::ST_COUNT;
        end
      end
      apd_pkg::ST_COUNT: begin
        if (!apd_en || strobe_act || !idle_level) begin
          cnt_d = '0; // [RL17] [RL13]
          st_d = apd_pkg::ST_RUN;
        end else if (cclk_rise) begin
          cnt_d = cnt_q + 4'h1; // [RL2]
          if (cnt_q == `IDLE_LIMIT - 4'h1) begin
            st_d = apd_pkg::ST_DOWN; // [RL2] [RL14]
          end
        end
      end
      apd_pkg::ST_DOWN: begin
        if (wake || !apd_en) begin
          cnt_d = '0;
          st_d = apd_pkg::ST_RUN; // [RL5] [RL6]
        end
      end
      default: begin
        cnt_d = '0;
        st_d = apd_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= apd_pkg::ST_RUN;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // gating and outputs
  // ****************************************
  logic pd;
  assign pd = st_q == apd_pkg::ST_DOWN;

  // memories only see chip select; logic arrays ignore it
  logic [7:0] maddr_d, mdata_d, dpo_d;
  logic msel_d, aov_d;
  logic [7:0] maddr_q, mdata_q, dpo_q;
  logic msel_q, aov_q;
  apd_pkg::logic_inputs_t li_d, li_q;

  always_comb begin
    maddr_d = pd ? maddr_q : host_addr; // [RL4]
    mdata_d = pd ? mdata_q : host_data; // [RL4]
    msel_d = !pd && !chip_select_n; // [RL4] [RL10]
    aov_d = !pd; // [RL9]
    dpo_d = data_port_out;
    // logic array inputs depend on blocking bits only, never on pd
    li_d.cntl0 = cntl0 && !pm_q.reg2[`PMR2_CNTL0_BIT]; // [RL11] [RL8]
    li_d.cntl1 = cntl1 && !pm_q.reg2[`PMR2_CNTL1_BIT]; // [RL11]
    li_d.cntl2 = cntl2 && !pm_q.reg2[`PMR2_CNTL2_BIT]; // [RL11]
    li_d.strobe = address_latch_strobe && !pm_q.reg2[`PMR2_STROBE_BIT]; // [RL11]
    li_d.dbe = dbe && !pm_q.reg2[`PMR2_DBE_BIT]; // [RL11]
    li_d.clk_en = !pm_q.reg0[`PMR0_CLK_BLOCK_BIT]; // [RL7]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maddr_q <= 8'h00;
      mdata_q <= 8'h00;
      msel_q <= 1'b0;
      aov_q <= 1'b1;
      dpo_q <= 8'h00;
      li_q <= '0;
    end else begin
      maddr_q <= maddr_d;
      mdata_q <= mdata_d;
      msel_q <= msel_d;
      aov_q <= aov_d;
      dpo_q <= dpo_d;
      li_q <= li_d;
    end
  end

  assign power_down_signal = pd;
  assign idle_count = cnt_q;
  assign mem_addr = maddr_q;
  assign mem_data = mdata_q;
  assign mem_select = msel_q;
  assign addr_out_valid = aov_q;
  assign data_port_o = dpo_q;
  assign data_port_oe = pd ? 8'h00 : 8'hFF; // [RL9]
  assign full_speed = !pm_q.reg0[`PMR0_FULL_SPEED_OFF_BIT]; // [RL15] [RL12] [RL8]
  assign power_mode = pm_q;
  assign logic_in = li_q;

  // ****************************************
  // checks
  // ****************************************
  sequence idle_run_s;
    apd_en && idle_level && !strobe_act;
  endsequence

  sequence run_idle_s;
    st_q == apd_pkg::ST_RUN ##0 idle_run_s;
  endsequence

  sequence steady_down_s;
    pd && !strobe_act;
  endsequence

  AST_NO_COUNT_DISABLED: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
    !apd_en |=> cnt_q == '0 && !pd) else $error("counter ran while disabled");
  AST_CLEAR_ON_ACT: assert property (@(posedge clk) disable iff (!rst_n) // [RL17]
    strobe_act |=> cnt_q == '0) else $error("counter not cleared by strobe");
  AST_ENTER_AT_15: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
    $rose(pd) |-> $past(cnt_q) == `IDLE_LIMIT - 4'h1 && cnt_q == `IDLE_LIMIT) else $error("bad entry count");
  AST_WAKE_STROBE: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
    pd && strobe_act |=> !pd) else $error("no wake on strobe");
  AST_WAKE_CS: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
    pd && cs_q && !chip_select_n |=> !pd) else $error("no wake on chip select");
  AST_MEM_DESEL: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
    pd |=> !mem_select) else $error("memory selected in power-down");
  AST_DATA_FLOAT: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
    pd |-> data_port_oe == 8'h00) else $error("data port driven in power-down");
  AST_CS_NOT_LOGIC: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
    !pm_q.reg2[`PMR2_CNTL0_BIT] ##1 !pm_q.reg2[`PMR2_CNTL0_BIT] |-> li_q.cntl0 == $past(cntl0))
    else $error("cntl0 not passed");
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
    st_q == apd_pkg::ST_COUNT ##0 idle_run_s ##0 cclk_rise |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("counter did not step");
  AST_FULL_SPEED: assert property (@(posedge clk) disable iff (!rst_n) // [RL15]
    pm_q.reg0[`PMR0_FULL_SPEED_OFF_BIT] |-> !full_speed)
    else $error("full speed not turned off");
  AST_FULL_SPEED_ON: assert property (@(posedge clk) disable iff (!rst_n) // [RL12]
    !pm_q.reg0[`PMR0_FULL_SPEED_OFF_BIT] |-> full_speed)
    else $error("full speed not turned on");

  // ****************************************
  // further checks on counting and gating
  // ****************************************
  // counter only leaves zero from the counting state
  AST_RUN_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
    st_q == apd_pkg::ST_RUN |-> cnt_q == '0)
    else $error("counter not zero while running");
  AST_WRONG_LEVEL: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
    !idle_level && !pd |=> cnt_q == '0)
    else $error("counter ran at wrong strobe level");
  AST_ARM: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
    run_idle_s |=> st_q == apd_pkg::ST_COUNT)
    else $error("enable alone did not arm counting");
  AST_HOLD_15: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
    pd |-> cnt_q == `IDLE_LIMIT)
    else $error("count not held in power-down");
  AST_ADDR_FREEZE: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
    steady_down_s |=> mem_addr == $past(mem_addr) && mem_data == $past(mem_data))
    else $error("host bus reached memories in power-down");
  AST_ADDR_PASS: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
    !pd |=> mem_addr == $past(host_addr) && mem_data == $past(host_data))
    else $error("host bus not passed in normal operation");
  AST_ADDR_UNDEF: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
    pd |=> !addr_out_valid)
    else $error("address out still valid in power-down");
  AST_OE_ON: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
    !pd |-> data_port_oe == 8'hFF)
    else $error("data port not driven in normal operation");
  // port data must keep flowing whatever the power state
  AST_PORT_DATA: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
    1'b1 |=> data_port_o == $past(data_port_out))
    else $error("port data disturbed");
  AST_WAKE_RST: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
    !rst_seen_q |=> !pd)
    else $error("no wake on reset release");
  AST_SEL_CS: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
    !pd && !chip_select_n |=> mem_select)
    else $error("memory not selected");
  AST_DESEL_CS: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
    chip_select_n |=> !mem_select)
    else $error("memory selected with chip select high");
  AST_STROBE_BLOCK: assert property (@(posedge clk) disable iff (!rst_n) // [RL11]
    pm_q.reg2[`PMR2_STROBE_BIT] |=> !li_q.strobe)
    else $error("blocked strobe reached logic arrays");
  // the array clock gate is separate from the counter clock
  AST_CLK_EN: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
    1'b1 |=> li_q.clk_en == !$past(pm_q.reg0[`PMR0_CLK_BLOCK_BIT]))
    else $error("array clock enable wrong");

endmodule : auto_power_down_unit
`default_nettype wire

// >>> testbench/host_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_mcu_model (
  input wire logic clk,
  input wire logic pulse_en,
  input wire logic idle_lvl,
  output logic strobe,
  output logic cclk
);
  initial begin
    strobe = 1'b0;
    cclk = 1'b0;
  end
  // common clock runs free, as an independent oscillator would while the host sleeps
  always @(negedge clk) begin
    cclk <= ~cclk;
    strobe <= pulse_en ? ~strobe : idle_lvl;
  end
endmodule : host_mcu_model
`default_nettype wire

// >>> testbench/auto_power_down_unit_bench.sv
`timescale 1ns/10ps
`default_nettype none
module auto_power_down_unit_bench;
  typedef struct packed {logic sel2; logic [7:0] d; logic [3:0] e;} row_t;
  logic clk, rst_n, por_n, pol, cs_n, wr0, wr2, pulse, lvl, stb, cck;
  logic pd, ms, fs, aov;
  logic [3:0] c4, ic;
  logic [7:0] wd, ha, hd, dpo, ma, md, dpd, dpoe;
  apd_pkg::power_mode_t pm;
  apd_pkg::logic_inputs_t li;
  int error_cnt, cmp_count;
  row_t rows [7] = '{'{1'b0, 8'h08, 4'h0}, '{1'b0, 8'h00, 4'h1}, '{1'b1, 8'h00, 4'hF},
    '{1'b1, 8'h04, 4'h7}, '{1'b1, 8'h08, 4'hB}, '{1'b1, 8'h10, 4'hD}, '{1'b1, 8'h40, 4'hE}};
  host_mcu_model host (.clk(clk), .pulse_en(pulse), .idle_lvl(lvl), .strobe(stb), .cclk(cck));
  auto_power_down_unit dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .common_clock_input(cck),
    .address_latch_strobe(stb), .strobe_pd_polarity(pol), .chip_select_n(cs_n), .reg_wr0(wr0),
    .reg_wr2(wr2), .reg_wdata(wd), .host_addr(ha), .host_data(hd), .cntl0(c4[3]), .cntl1(c4[2]),
    .cntl2(c4[1]), .dbe(c4[0]), .data_port_out(dpo), .power_mode(pm), .logic_in(li),
    .power_down_signal(pd), .idle_count(ic), .mem_addr(ma), .mem_data(md), .mem_select(ms),
    .full_speed(fs), .data_port_o(dpd), .data_port_oe(dpoe), .addr_out_valid(aov));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude;
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic sel2, input logic [7:0] d);
    @(negedge clk);
    wr0 = !sel2;
    wr2 = sel2;
    wd = d;
    @(negedge clk);
    wr0 = 1'b0;
    wr2 = 1'b0;
  endtask : wr
  // bounded wait; running out ends the run as a failure
  task automatic wait_pd;
    int k;
    for (k = 0; k < 100 && pd !== 1'b1; k++) @(negedge clk);
    if (pd !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask : wait_pd
  initial begin
    {rst_n, por_n, cs_n, wr0, wr2} = 5'h00;
    {pol, pulse, lvl} = 3'h7;
    {wd, ha, hd, dpo} = 32'h00A55AC3;
    c4 = 4'hF;
    error_cnt = 0;
    cmp_count = 0;
    cyc(3);
    rst_n = 1'b1;
    por_n = 1'b1;
    cyc(2);
    chk("power_mode", pm, 16'h0000);
    chk("full_speed", fs, 16'h0001);
    chk("mem_select", ms, 16'h0001);
    chk("mem_bus", {ma, md}, 16'hA55A);
    chk("data_port", {dpd, dpoe}, 16'hC3FF);
    foreach (rows[r]) begin
      wr(rows[r].sel2, rows[r].d);
      cyc(1);
      chk("row", rows[r].sel2 ? {li.cntl0, li.cntl1, li.cntl2, li.dbe} : {3'h0, fs}, rows[r].e);
    end
    pulse = 1'b0;
    cyc(40);
    chk("pd_off", {pd, ic}, 16'h0000);
    wr(1'b0, 8'h02);
    lvl = 1'b0;
    cyc(40);
    chk("pd_lvl", {pd, ic}, 16'h0000);
    lvl = 1'b1;
    cyc(20);
    chk("pd_early", pd, 16'h0000);
    wait_pd();
    chk("idle_count", ic, 16'h000F);
    ha = 8'h3C;
    hd = 8'h66;
    cyc(2);
    chk("frozen", {ma, md}, 16'hA55A);
    chk("blocked", {ms, dpoe, aov}, 16'h0000);
    chk("logic", {li.cntl0, li.cntl1, li.cntl2, li.dbe, fs}, 16'h001D);
    pulse = 1'b1;
    cyc(2);
    chk("wake_strobe", {pd, ic}, 16'h0000);
    pulse = 1'b0;
    cs_n = 1'b1;
    cyc(2);
    chk("cs_high", {ms, li.cntl0, li.cntl1, li.cntl2, li.dbe}, 16'h000E);
    chk("mem_bus_woken", {ma, md}, 16'h3C66);
    wait_pd();
    cs_n = 1'b0;
    cyc(2);
    chk("wake_cs", pd, 16'h0000);
    wait_pd();
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    cyc(2);
    chk("wake_rst", pd, 16'h0000);
    chk("pm_kept", pm, 16'h0240);
    wr(1'b0, 8'h12);
    wait_pd();
    chk("pd_clk_blocked", pd, 16'h0001);
    conclude();
  end
endmodule : auto_power_down_unit_bench
`default_nettype wire
